/* core/dba_pkg.sv */
// Shared constants and types for the data break and interrupt arbiter
package dba_pkg;

	// ****************************************
	// Clock and memory cycle timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int MEM_CYCLE_NS  = 1400;
	localparam int SAMPLE_LEAD_NS = 300;
	localparam int CYC_CLKS    = MEM_CYCLE_NS / CLK_PERIOD_NS;
	// Least lead, rounded up to whole cycles
	localparam int SAMPLE_CLKS = (SAMPLE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
	localparam logic [CNT_W-1:0] CYC_LAST  = CNT_W'(CYC_CLKS - 1);
	localparam logic [CNT_W-1:0] SAMPLE_AT = CNT_W'(CYC_CLKS - SAMPLE_CLKS);

	// Service latency bounds seen by a break requester
	localparam int BRK_LAT_INTERNAL_NS = 1700;
	localparam int BRK_LAT_EXT_IO_NS   = 4900;
	localparam int BRK_LAT_INTERNAL_CLKS = BRK_LAT_INTERNAL_NS / CLK_PERIOD_NS;
	localparam int BRK_LAT_EXT_IO_CLKS   = BRK_LAT_EXT_IO_NS / CLK_PERIOD_NS;
	localparam int FLAG_BLIND_NS = 300;

	// ****************************************
	// Break lengths and instruction codes
	// ****************************************
	localparam logic [1:0] BRK_MORE_NONE  = 2'h0;
	localparam logic [1:0] BRK_MORE_THREE = 2'h2;
	localparam logic [1:0] BRK_MORE_STEP  = 2'h1;

	localparam int OP_W = 12;
	localparam logic [OP_W-1:0] OP_SKIP_IF_INT_PENDING = 12'hc03; // octal 6003
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] INT_VECTOR_ADDR = 12'h000;

	// ****************************************
	// Memory owner state, Gray coded
	// ****************************************
	typedef enum logic [1:0] {
		DBA_OWN_CPU = 2'b00,
		DBA_OWN_BRK = 2'b01,
		DBA_OWN_INT = 2'b11
	} dba_owner_e;

endpackage : dba_pkg

/* core/dba_sync3.sv */
// Three-stage input synchroniser with agreement filter
module dba_sync3
	import dba_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] level;
	} dba_sync_s;

	dba_sync_s st;
	dba_sync_s next_st;

	always_comb
	begin
		next_st     = st;
		next_st.ff1 = async_i;
		next_st.ff2 = st.ff1;
		next_st.ff3 = st.ff2;
		// Only a bit whose last two stages agree may change
		next_st.level = (~(st.ff2 ^ st.ff3) & st.ff3) | ((st.ff2 ^ st.ff3) & st.level);
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign sync_o = st.level;

endmodule : dba_sync3

/* core/dba_prio_pick.sv */
// Fixed priority picker, index zero highest
module dba_prio_pick
	import dba_pkg::*;
#(
	parameter int N = 4
)(
	input  wire logic [N-1:0] req_i,
	output logic      [N-1:0] gnt_o
);

	logic [N-1:0] taken_above;

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_pick
			if (gi == 0)
			begin : g_first
				assign taken_above[gi] = 1'b0;
			end
			else
			begin : g_rest
				assign taken_above[gi] = taken_above[gi-1] | req_i[gi-1];
			end
			assign gnt_o[gi] = req_i[gi] & ~taken_above[gi];
		end
	endgenerate

endmodule : dba_prio_pick

/* core/dba_arbiter.sv */
// Memory cycle timer and data break / program interrupt arbiter
module dba_arbiter
	import dba_pkg::*;
#(
	parameter int N_BRK = 4
)(
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic [N_BRK-1:0]  brk_req_i,
	input  wire logic [N_BRK-1:0]  brk_three_i,
	input  wire logic              int_req_i,
	input  wire logic              int_enable_i,
	input  wire logic              fetch_next_i,
	input  wire logic              io_stall_i,
	input  wire logic              instr_valid_i,
	input  wire logic [OP_W-1:0]   instr_op_i,
	output logic                   cycle_end_o,
	output logic                   sample_o,
	output logic [N_BRK-1:0]       brk_grant_o,
	output logic                   brk_active_o,
	output logic                   int_ack_o,
	output logic                   force_jsr_o,
	output logic [ADDR_W-1:0]      jsr_addr_o,
	output logic                   skip_o
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [CNT_W-1:0] cyc_cnt;
		logic [N_BRK-1:0] brk_seen;
		logic [N_BRK-1:0] three_seen;
		logic             int_seen;
		dba_owner_e       owner;
		logic [1:0]       brk_more;
		logic [N_BRK-1:0] grant;
		logic             cycle_end;
		logic             sample;
		logic             int_ack;
		logic             skip;
		logic             brk_active;
		logic             force_jsr;
	} dba_arb_s;

	dba_arb_s st;
	dba_arb_s next_st;

	logic [N_BRK-1:0] brk_req_sync;
	logic [N_BRK-1:0] brk_three_sync;
	logic             int_req_sync;
	logic [N_BRK-1:0] brk_pick;

	// ****************************************
	// Pin synchronisers and priority picker
	// ****************************************
	dba_sync3 #(
		.W (2 * N_BRK + 1)
	) u_sync (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.async_i ({int_req_i, brk_three_i, brk_req_i}),
		.sync_o  ({int_req_sync, brk_three_sync, brk_req_sync})
	);

	// Caller wires the shortest-lifetime requester to index zero
	dba_prio_pick #(
		.N (N_BRK)
	) u_pick (
		.req_i (st.brk_seen),
		.gnt_o (brk_pick)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		next_st           = st;
		next_st.cycle_end = 1'b0;
		next_st.sample    = 1'b0;
		next_st.int_ack   = 1'b0;
		next_st.skip      = 1'b0;

		// Cycle timer; an external I/O pause stretches the cycle
		if (st.cyc_cnt != CYC_LAST)
			next_st.cyc_cnt = CNT_W'(st.cyc_cnt + 1'b1);
		else if (!io_stall_i)
			next_st.cyc_cnt = CNT_ZERO;

		// One look per cycle: a flag set just after it waits a cycle
		if (st.cyc_cnt == SAMPLE_AT)
		begin
			next_st.sample     = 1'b1;
			next_st.brk_seen   = brk_req_sync;
			next_st.three_seen = brk_three_sync;
			next_st.int_seen   = int_req_sync;
		end

		// Decide the owner of the next memory cycle at the boundary
		if (st.cyc_cnt == CYC_LAST && !io_stall_i)
		begin
			next_st.cycle_end = 1'b1;
			if (st.owner == DBA_OWN_BRK && st.brk_more != BRK_MORE_NONE)
			begin
				// No preemption mid-break, even by a higher requester
				next_st.brk_more = st.brk_more - BRK_MORE_STEP;
			end
			else if (st.brk_seen != '0)
			begin
				next_st.owner    = DBA_OWN_BRK;
				next_st.grant    = brk_pick;
				next_st.brk_more = ((brk_pick & st.three_seen) != '0) ?
					BRK_MORE_THREE : BRK_MORE_NONE;
			end
			else if (st.int_seen && int_enable_i && fetch_next_i)
			begin
				next_st.owner    = DBA_OWN_INT;
				next_st.grant    = '0;
				next_st.brk_more = BRK_MORE_NONE;
				next_st.int_ack  = 1'b1;
			end
			else
			begin
				next_st.owner    = DBA_OWN_CPU;
				next_st.grant    = '0;
				next_st.brk_more = BRK_MORE_NONE;
			end
		end

		if (instr_valid_i && instr_op_i == OP_SKIP_IF_INT_PENDING)
			next_st.skip = int_req_sync;

		// Owner flags kept in flops so the pins come straight from a register
		next_st.brk_active = (next_st.owner == DBA_OWN_BRK);
		next_st.force_jsr  = (next_st.owner == DBA_OWN_INT);
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			st       <= '0;
			st.owner <= DBA_OWN_CPU;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign cycle_end_o  = st.cycle_end;
	assign sample_o     = st.sample;
	assign brk_grant_o  = st.grant;
	assign brk_active_o = st.brk_active;
	assign int_ack_o    = st.int_ack;
	assign force_jsr_o  = st.force_jsr;
	assign jsr_addr_o   = INT_VECTOR_ADDR;
	assign skip_o       = st.skip;

endmodule : dba_arbiter

/* tb/dba_checker.sv */
// Port checks for the break and interrupt arbiter
module dba_checker
	import dba_pkg::*;
#(
	parameter int N_BRK = 4
)(
	input wire logic             clk_i,
	input wire logic             srst_i,
	input wire logic [N_BRK-1:0] brk_req_i,
	input wire logic [N_BRK-1:0] brk_three_i,
	input wire logic             int_req_i,
	input wire logic             int_enable_i,
	input wire logic             fetch_next_i,
	input wire logic             io_stall_i,
	input wire logic             instr_valid_i,
	input wire logic [OP_W-1:0]  instr_op_i,
	input wire logic             cycle_end_o,
	input wire logic             sample_o,
	input wire logic [N_BRK-1:0] brk_grant_o,
	input wire logic             brk_active_o,
	input wire logic             int_ack_o,
	input wire logic             force_jsr_o,
	input wire logic [ADDR_W-1:0] jsr_addr_o,
	input wire logic             skip_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_sample_point: assert property (cycle_end_o |-> ##111 sample_o)
		else $error("sample pulse misplaced");
	a_one_grant: assert property ($onehot0(brk_grant_o))
		else $error("several grants");
	a_grant_hold: assert property (!cycle_end_o |-> $stable(brk_grant_o))
		else $error("grant moved mid cycle");
	a_grant_edge: assert property ($rose(brk_active_o) |-> cycle_end_o)
		else $error("break began off boundary");
	a_int_fetch: assert property (int_ack_o |-> cycle_end_o && force_jsr_o && !brk_active_o
		&& $past(fetch_next_i) && jsr_addr_o == INT_VECTOR_ADDR)
		else $error("interrupt taken wrongly");
	a_jsr_hold: assert property ($changed(force_jsr_o) |-> cycle_end_o)
		else $error("forced jump not one cycle");
	a_skip_cause: assert property (skip_o |-> $past(instr_valid_i)
		&& $past(instr_op_i) == OP_SKIP_IF_INT_PENDING)
		else $error("skip without its opcode");
	a_brk_fast: assert property ($rose(brk_req_i[0]) && !brk_active_o && !io_stall_i
		|-> ##[1:180] brk_grant_o[0])
		else $error("break service late");
endmodule : dba_checker

bind dba_arbiter dba_checker #(.N_BRK(N_BRK)) u_chk (.*);

/* tb/dba_periph.sv */
// Model of the break requesting peripheral controllers
module dba_periph
	import dba_pkg::*;
#(
	parameter int N = 4
)(
	input  wire logic         clk_i,
	input  wire logic [N-1:0] want_i,
	input  wire logic [N-1:0] three_i,
	input  wire logic [N-1:0] grant_i,
	output logic      [N-1:0] req_o,
	output logic      [N-1:0] three_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [N-1:0] len  = '0;
	logic [N-1:0] junk = '0;
	// Index 0 is wired to the shortest-lived data source
	initial req_o = '0;
	always @(posedge clk_i)
	begin
		junk <= ~junk;
		req_o <= (req_o & ~grant_i) | want_i;
		len <= (len & ~want_i) | (three_i & want_i);
	end
	// Idle length line toggles so no stale value survives
	assign three_o = (req_o & len) | (~req_o & junk);
endmodule : dba_periph

/* tb/dba_arbiter_tb.sv */
// Self-checking bench for the break and interrupt arbiter
module dba_arbiter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dba_pkg::*;
	logic              clk_i = 1'h0;
	logic              srst_i = 1'h1;
	logic [3:0]        brk_req_i, brk_three_i, brk_grant_o;
	logic [3:0]        want = 4'h0;
	logic [3:0]        three = 4'h0;
	logic              int_req_i = 1'h0;
	logic              int_enable_i = 1'h1;
	logic              fetch_next_i = 1'h0;
	logic              io_stall_i = 1'h0;
	logic              instr_valid_i = 1'h0;
	logic [OP_W-1:0]   instr_op_i = 12'h000;
	logic              cycle_end_o, sample_o, brk_active_o, int_ack_o, force_jsr_o, skip_o;
	logic [ADDR_W-1:0] jsr_addr_o;
	int                n_errors = 0;
	int                checked = 0;
	int                w, l;

	dba_arbiter DUT (.*);
	dba_periph u_per (.clk_i(clk_i), .want_i(want), .three_i(three), .grant_i(brk_grant_o),
		.req_o(brk_req_i), .three_o(brk_three_i));

	initial forever #5 clk_i = ~clk_i;

	task tick;
		@(posedge clk_i);
		#1;
	endtask : tick

	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask : chk

	task give_verdict;
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	task glen(input int k);
		w = 0;
		l = 0;
		while (brk_grant_o[k] !== 1'h1 && w < 600)
		begin
			tick;
			w++;
		end
		while (brk_grant_o[k] === 1'h1 && l < 600)
		begin
			tick;
			l++;
		end
	endtask : glen

	task req(input logic [3:0] m, input logic [3:0] t);
		three = t;
		want = m;
		tick;
		want = 4'h0;
	endtask : req

	task t_one;
		req(4'h4, 4'h0);
		glen(2);
		chk("one wait", w <= 180, 1'h1);
		chk("one len", 16'(l), 16'h008c);
	endtask : t_one

	task t_stall;
		io_stall_i = 1'h1;
		req(4'h2, 4'h2);
		repeat (200) tick;
		chk("stall hold", brk_grant_o[1], 1'h0);
		io_stall_i = 1'h0;
		glen(1);
		chk("stall wait", w + 201 <= BRK_LAT_EXT_IO_CLKS, 1'h1);
		chk("three len", 16'(l), 16'h01a4);
	endtask : t_stall

	task t_prio;
		req(4'h9, 4'h8);
		glen(0);
		chk("first len", 16'(l), 16'h008c);
		chk("active", brk_active_o, 1'h1);
		glen(3);
		chk("second wait", 16'(w), 16'h0000);
		chk("second len", 16'(l), 16'h01a4);
	endtask : t_prio

	task t_int;
		int_req_i = 1'h1;
		w = 0;
		repeat (300)
		begin
			tick;
			w += int_ack_o;
		end
		chk("ack off fetch", 16'(w), 16'h0000);
		fetch_next_i = 1'h1;
		l = 0;
		while (int_ack_o !== 1'h1 && l < 300)
		begin
			tick;
			l++;
		end
		chk("ack", int_ack_o, 1'h1);
		chk("jsr addr", jsr_addr_o, INT_VECTOR_ADDR);
		fetch_next_i = 1'h0;
		int_req_i = 1'h0;
		l = 0;
		while (force_jsr_o === 1'h1 && l < 600)
		begin
			tick;
			l++;
		end
		chk("jsr len", 16'(l), 16'h008c);
	endtask : t_int

	task t_skip(input logic r, input logic [OP_W-1:0] op, input logic e);
		int_req_i = r;
		repeat (6) tick;
		instr_valid_i = 1'h1;
		instr_op_i = op;
		tick;
		instr_valid_i = 1'h0;
		chk("skip", skip_o, e);
	endtask : t_skip

	initial
	begin
		repeat (10) @(posedge clk_i);
		#1;
		srst_i = 1'h0;
		t_one;
		t_stall;
		t_prio;
		t_int;
		t_skip(1'h1, OP_SKIP_IF_INT_PENDING, 1'h1);
		t_skip(1'h1, 12'hc02, 1'h0);
		t_skip(1'h0, OP_SKIP_IF_INT_PENDING, 1'h0);
		give_verdict;
	end

	initial
	begin
		#200000;
		n_errors++;
		give_verdict;
	end
endmodule : dba_arbiter_tb
